// [design/mhp_ctrl.sv]
// Memory port hot-plug controller: per-port event flags, control bits,
// the shared interval timer, the directory-cache flush handshake and the
// hot-plug interrupt. Assumes an APB master on pclk and slot pins that
// are asynchronous to pclk; the flush engine sits outside.
`timescale 1ns/1ns

// Summary of operation
// (R1) A bridge in-band alert sets the port bridge-event flag and interrupts.
// (R2) Latch change, presence change and power fault set flags and interrupt.
// (R3) Port entering disabled sets port-failed flag, only in mirror or RAID.
// (R4) A fatal port error in a redundant mode switches that port to fail-over; the code does so only from the active or redundant port state.
// (R5) An attention button press sets the button-event flag and interrupts.
// (R6) Timer interval expiry sets the timer-expired flag and interrupts.
// (R7) One shared timer, interval 12.5 ms to 12.5 s.
// (R8) Writing the flush bit starts a directory-cache flush.
// (R9) Flush completion sets the flush-done status bit.
// (R10) Software polls flush-done about every 25 ms using the timer.
// (R11) Software resets the port after flush, then power off, then LED off.
// (R12) Writing reset into a port's next-state field puts the port in reset.
// (R13) In redundant modes software writes recovery-reset, not plain reset.
// (R14) Setting the slot power control bit switches slot power off.
// (R15) Power LED control gives off, on and blinking on the green LED.
// (R16) Attention LED control switches the amber LED on or off.
// (R17) Software removes a redundant port by writing the disabled state.
// (R18) Second button press within the interval cancels removal, by software.
// (R19) One hot-plug operation at a time; per-port interrupt enable masks.
// (R20) Flags hold until written one; interrupt is OR of enabled set flags.
// (R21) A new event on a set flag keeps it set and is never lost.
module mhp_ctrl
  import mhp_pkg::*;
#(
  parameter int unsigned NP       = NUM_PORTS,
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Slot pins
  input  wire mhp_slot_in_s [NP-1:0] slot_in,
  output mhp_slot_out_s     [NP-1:0] slot_out,
  // Directory-cache flush engine
  output logic                     dc_flush_start,
  input  wire logic                dc_flush_done,
  // Interrupt
  output logic                     hotplug_irq_out
);
  localparam int unsigned SW = $bits(mhp_slot_in_s);

  logic [31:0]        ctrl_q [NP];
  logic [NUM_EV-1:0]  flag_q [NP];
  mhp_port_state_e    pstate_q [NP];
  mhp_slot_in_s [NP-1:0] pin_s;
  mhp_slot_in_s [NP-1:0] prev_q;
  logic [9:0]         tmr_ticks_q;
  logic               tmr_flag_q;
  logic               tmr_ien_q;
  logic               flush_busy_q;
  logic               flush_done_q;
  mhp_mode_e          mode_q;
  logic               blink_q;
  logic [5:0]         blink_cnt_q;
  logic               tick;
  logic               tmr_run;
  logic               tmr_exp;
  logic               wr;
  logic               rd_ok;
  logic [NP-1:0]      irq_port;
  logic               redundant;

  assign wr        = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign redundant = (mode_q == MHP_MODE_MIRROR) || (mode_q == MHP_MODE_RAID);

  mhp_sync #(.W(NP * SW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (slot_in),
    .sync_o  (pin_s)
  );

  mhp_timer #(.TICK_CYC(TICK_CYC)) u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start_i   (wr && (paddr == OFS_TIMER)),
    .ticks_i   (pwdata[9:0]),
    .tick_o    (tick),
    .running_o (tmr_run),
    .expired_o (tmr_exp)
  );

  // Blink source for the green LED, derived from the shared tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_q     <= 1'b0;
      blink_cnt_q <= '0;
    end else if (tick) begin
      if (blink_cnt_q == BLINK_TICKS - 6'h01) begin
        blink_cnt_q <= '0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 6'h01;
      end
    end
  end

  // Global registers: timer interval, mode and flush handshake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_ticks_q  <= TIMER_MIN_TICKS;
      tmr_flag_q   <= 1'b0;
      tmr_ien_q    <= 1'b0;
      mode_q       <= MHP_MODE_NORMAL;
      flush_busy_q <= 1'b0;
      flush_done_q <= 1'b0;
    end else begin
      if (wr && paddr == OFS_TIMER) begin
        tmr_ticks_q <= pwdata[9:0];
        tmr_ien_q   <= pwdata[16];
      end
      // Expiry wins over a same-cycle write-one clear.
      if (tmr_exp) begin
        tmr_flag_q <= 1'b1; // [R6] [R21]
      end else if (wr && paddr == OFS_TIMER && pwdata[31]) begin
        tmr_flag_q <= 1'b0; // [R20]
      end
      if (wr && paddr == OFS_MODE) begin
        mode_q <= mhp_mode_e'(pwdata[1:0]);
      end
      if (wr && paddr == OFS_DCCTRL && pwdata[0] && !flush_busy_q) begin
        flush_busy_q <= 1'b1; // [R8]
        flush_done_q <= 1'b0;
      end else if (flush_busy_q && dc_flush_done) begin
        flush_busy_q <= 1'b0;
        flush_done_q <= 1'b1; // [R9]
      end
    end
  end

  assign dc_flush_start = wr && paddr == OFS_DCCTRL && pwdata[0]
                          && !flush_busy_q; // [R8]

  for (genvar p = 0; p < NP; p++) begin : g_port
    logic [NUM_EV-1:0] ev;
    logic              wr_ctl;
    logic              wr_st;
    logic              fail_now;

    assign wr_ctl = wr && (paddr == OFS_CTRL0 + 8'(4 * p));
    assign wr_st  = wr && (paddr == OFS_STAT0 + 8'(4 * p));
    assign fail_now = redundant && pin_s[p].fatal_err
                      && !prev_q[p].fatal_err
                      && (pstate_q[p] == MHP_ST_REDUNDANT ||
                          pstate_q[p] == MHP_ST_ACTIVE);

    always_comb begin
      ev = '0;
      ev[EV_BRIDGE] = pin_s[p].bridge_alert && !prev_q[p].bridge_alert; // [R1]
      ev[EV_LATCH]  = pin_s[p].latch_open != prev_q[p].latch_open;     // [R2]
      ev[EV_PRES]   = pin_s[p].present != prev_q[p].present;           // [R2]
      ev[EV_PFAULT] = pin_s[p].power_fault && !prev_q[p].power_fault;  // [R2]
      ev[EV_BUTTON] = pin_s[p].button && !prev_q[p].button;            // [R5]
      // Only redundant modes report a port dropping to disabled.
      ev[EV_FAILED] = redundant && (fail_now ||
                      (wr_ctl && pwdata[CTL_NEXT_VLD] &&
                       pwdata[CTL_NEXT_LSB +: 4] == MHP_ST_DISABLED)); // [R3]
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev_q[p] <= '0;
      end else begin
        prev_q[p] <= pin_s[p];
      end
    end

    // Set has priority over the write-one clear.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_q[p] <= '0;
      end else begin
        flag_q[p] <= ev | (flag_q[p] & ~(wr_st ? pwdata[NUM_EV-1:0]
                                             : '0)); // [R20] [R21]
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_q[p]   <= CTL_RESET;
        pstate_q[p] <= MHP_ST_RESET;
      end else begin
        if (wr_ctl) begin
          // The next-state strobe in bit 8 is not stored.
          ctrl_q[p] <= {10'h000, pwdata[21:16], 8'h00, pwdata[7:0]};
        end
        if (fail_now) begin
          pstate_q[p] <= MHP_ST_FAILOVER; // [R4]
        end else if (wr_ctl && pwdata[CTL_NEXT_VLD]) begin
          pstate_q[p] <= mhp_port_state_e'(pwdata[CTL_NEXT_LSB +: 4]);
        end
      end
    end

    // Port reset covers both plain and recovery reset.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        slot_out[p] <= '{green_led: 1'b0, amber_led: 1'b0,
                         slot_power_en: 1'b0, port_reset: 1'b1};
      end else begin
        slot_out[p].port_reset <= pstate_q[p] == MHP_ST_RESET ||
                                  pstate_q[p] == MHP_ST_REC_RESET; // [R12]
        slot_out[p].slot_power_en <= !ctrl_q[p][CTL_PWROFF];       // [R14]
        slot_out[p].amber_led <= ctrl_q[p][CTL_ALED];              // [R16]
        unique case (mhp_led_e'(ctrl_q[p][CTL_PLED_LSB +: 2]))
          MHP_LED_ON:    slot_out[p].green_led <= 1'b1;            // [R15]
          MHP_LED_BLINK: slot_out[p].green_led <= blink_q;         // [R15]
          default:       slot_out[p].green_led <= 1'b0;
        endcase
      end
    end

    // Per-port enables hold off events of ports not being serviced.
    assign irq_port[p] = |(flag_q[p] &
                           ctrl_q[p][CTL_IEN_LSB +: NUM_EV]); // [R19]
  end

  assign hotplug_irq_out = (|irq_port) || (tmr_flag_q && tmr_ien_q); // [R20]

  // Read mux; unmapped addresses read zero with pslverr.
  always_comb begin
    prdata = '0;
    rd_ok  = 1'b1;
    if (paddr < OFS_STAT0 && paddr[1:0] == 2'b00) begin
      prdata = ctrl_q[paddr[3:2]];
    end else if (paddr < OFS_TIMER && paddr[1:0] == 2'b00) begin
      prdata = {20'h0_0000, pstate_q[paddr[3:2]], 2'b00, flag_q[paddr[3:2]]};
    end else if (paddr == OFS_TIMER) begin
      prdata = {tmr_flag_q, 13'h0000, tmr_run, tmr_ien_q, 6'h00, tmr_ticks_q};
    end else if (paddr == OFS_DCCTRL) begin
      prdata = {31'h0000_0000, flush_busy_q};
    end else if (paddr == OFS_DCSTAT) begin
      prdata = {31'h0000_0000, flush_done_q}; // [R9]
    end else if (paddr == OFS_MODE) begin
      prdata = {30'h0000_0000, mode_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !rd_ok;

endmodule : mhp_ctrl

// [design/mhp_pkg.sv]
// Package for the memory port hot-plug controller: register map, field
// layout, port states and timer constants shared by the controller, the timer and the test files.
// Assumes a 125 MHz APB clock.
package mhp_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned CLK_HZ    = 125_000_000;

  // Hot-plug timer tick of 12.5 ms; the interval register counts ticks.
  localparam int unsigned TICK_US     = 12_500;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICK_W      = 21;
  // 1 tick is 12.5 ms, 1000 ticks are 12.5 s.
  localparam logic [9:0] TIMER_MIN_TICKS = 10'h001;
  localparam logic [9:0] TIMER_MAX_TICKS = 10'h3E8;
  // Blink half period of the power LED, in hot-plug ticks.
  localparam logic [5:0] BLINK_TICKS = 6'h28;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL0   = 8'h00; // port_hotplug_ctrl_reg, 4 ea
  localparam logic [7:0] OFS_STAT0   = 8'h10; // port_status_reg, 4 each
  localparam logic [7:0] OFS_TIMER   = 8'h20; // hotplug_interval_timer
  localparam logic [7:0] OFS_DCCTRL  = 8'h24; // dir_cache_ctrl_reg
  localparam logic [7:0] OFS_DCSTAT  = 8'h28; // dir_cache_status_reg
  localparam logic [7:0] OFS_MODE    = 8'h2C; // redundancy mode

  // Status event bit positions.
  localparam int unsigned EV_BRIDGE = 0;
  localparam int unsigned EV_LATCH  = 1;
  localparam int unsigned EV_BUTTON = 2;
  localparam int unsigned EV_FAILED = 3;
  localparam int unsigned EV_PRES   = 4;
  localparam int unsigned EV_PFAULT = 5;
  localparam int unsigned NUM_EV    = 6;
  localparam int unsigned STATE_LSB = 8;

  // Control field positions.
  localparam int unsigned CTL_PLED_LSB = 0;  // 2 bits
  localparam int unsigned CTL_ALED     = 2;
  localparam int unsigned CTL_PWROFF   = 3;
  localparam int unsigned CTL_NEXT_LSB = 4;  // 4 bits
  localparam int unsigned CTL_NEXT_VLD = 8;  // write strobe for next state
  localparam int unsigned CTL_IEN_LSB  = 16; // 6 bits
  localparam logic [31:0] CTL_RESET    = 32'h0000_0001;

  typedef enum logic [1:0] {
    MHP_LED_OFF = 2'h0, MHP_LED_ON = 2'h1, MHP_LED_BLINK = 2'h2
  } mhp_led_e;

  typedef enum logic [3:0] {
    MHP_ST_RESET     = 4'h0, MHP_ST_READY    = 4'h1,
    MHP_ST_ACTIVE    = 4'h2, MHP_ST_DISABLED = 4'h3,
    MHP_ST_REDUNDANT = 4'h4, MHP_ST_FAILOVER = 4'h5,
    MHP_ST_REC_RESET = 4'h6
  } mhp_port_state_e;

  typedef enum logic [1:0] {
    MHP_MODE_NORMAL = 2'h0, MHP_MODE_MIRROR = 2'h1, MHP_MODE_RAID = 2'h2
  } mhp_mode_e;

  // Pin-side signals of one slot.
  typedef struct packed {
    logic bridge_alert;
    logic latch_open;
    logic button;
    logic present;
    logic power_fault;
    logic fatal_err;
  } mhp_slot_in_s;

  typedef struct packed {
    logic green_led;
    logic amber_led;
    logic slot_power_en;
    logic port_reset;
  } mhp_slot_out_s;

endpackage : mhp_pkg

// [design/mhp_sync.sv]
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes the inputs are slow levels with no bus-wide coherency need.
`timescale 1ns/1ns
module mhp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : mhp_sync

// [design/mhp_timer.sv]
// Shared hot-plug interval timer: a 12.5 ms tick divider and a tick
// counter that pulses expiry once the programmed interval has passed.
// Assumes one clock; start restarts the count.
`timescale 1ns/1ns
module mhp_timer
  import mhp_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       start_i,
  input  wire logic [9:0] ticks_i,
  // Status
  output logic            tick_o,
  output logic            running_o,
  output logic            expired_o
);
  logic [TICK_W-1:0] div_q;
  logic [9:0]        cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (div_q == TICK_W'(TICK_CYC - 1));
      if (div_q == TICK_W'(TICK_CYC - 1)) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // Interval is clamped into 12.5 ms .. 12.5 s.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= '0;
      running_o <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      if (start_i) begin
        running_o <= 1'b1; // [R7]
        cnt_q <= (ticks_i < TIMER_MIN_TICKS) ? TIMER_MIN_TICKS :
                 (ticks_i > TIMER_MAX_TICKS) ? TIMER_MAX_TICKS : ticks_i;
      end else if (running_o && tick_o) begin
        if (cnt_q == 10'h001) begin
          running_o <= 1'b0;
          expired_o <= 1'b1; // [R6]
        end
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : mhp_timer

// [test/memory_port_hot_removal_ctrl_tb.sv]
// Self-checking bench: APB master, card model on port 0, pin event table.
// Assumes a 10-cycle timer tick so that expiry comes quickly.
`timescale 1ns/1ns
module memory_port_hot_removal_ctrl_tb
  import mhp_pkg::*;
;
  typedef struct packed {
    logic [5:0] pin;
    logic [5:0] flag;
    logic       irq;
  } mhp_row_s;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = '0;
  logic [31:0]           pwdata = '0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [5:0]            pins_req = '0;
  logic [7:0]            flush_lat = 8'h02;
  mhp_slot_in_s  [3:0]   slot_in;
  mhp_slot_out_s [3:0]   slot_out;
  logic                  dc_flush_start;
  logic                  dc_flush_done;
  logic                  hotplug_irq_out;
  logic [31:0]           rd;
  logic                  er;
  int                    failures = 0;
  int                    samples_checked = 0;
  mhp_row_s rows [6] = '{'{6'h20, 6'h01, 1'b1}, '{6'h10, 6'h02, 1'b1},
    '{6'h08, 6'h04, 1'b1}, '{6'h04, 6'h10, 1'b1},
    '{6'h02, 6'h20, 1'b1}, '{6'h01, 6'h00, 1'b0}};
  always #4 pclk = ~pclk;
  mhp_ctrl #(.NP(4), .TICK_CYC(10)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_in(slot_in), .slot_out(slot_out),
    .dc_flush_start(dc_flush_start), .dc_flush_done(dc_flush_done),
    .hotplug_irq_out(hotplug_irq_out));
  mhp_card_model #(.NP(4)) u_card (.pclk(pclk), .presetn(presetn),
    .pins_req(pins_req), .flush_lat(flush_lat), .slot_in(slot_in),
    .dc_flush_start(dc_flush_start), .dc_flush_done(dc_flush_done));
  task automatic stop_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      stop_test();
    end
    // Slot outputs follow the control register one edge later.
    repeat (2) @(negedge pclk);
  endtask : apb
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, '0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      stop_test();
    end
  endtask : poll
  task automatic pin(input logic [5:0] p);
    @(posedge pclk);
    pins_req <= p;
    repeat (6) @(posedge pclk);
    pins_req <= '0;
    repeat (8) @(posedge pclk);
  endtask : pin
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("slot_out", 32'h0000_000B, 32'(slot_out[0]));
    apb(1'b0, OFS_CTRL0, '0);
    chk("ctrl0", CTL_RESET, rd);
    apb(1'b1, OFS_CTRL0, 32'h003F_0121);
    chk("port_reset", 32'h0, 32'(slot_out[0].port_reset));
    apb(1'b1, OFS_CTRL0, 32'h003F_0101);
    chk("port_reset", 32'h1, 32'(slot_out[0].port_reset));
    foreach (rows[i]) begin
      pin(rows[i].pin);
      apb(1'b0, OFS_STAT0, '0);
      chk("flags", 32'(rows[i].flag), 32'(rd[5:0]));
      chk("irq", 32'(rows[i].irq), 32'(hotplug_irq_out));
      apb(1'b1, OFS_STAT0, 32'(rows[i].flag));
      chk("irq clr", 32'h0, 32'(hotplug_irq_out));
    end
    // Masked port: the flag still records the event, the output stays low.
    apb(1'b1, OFS_CTRL0, 32'h0000_0001);
    pin(6'h08);
    pin(6'h08);
    apb(1'b0, OFS_STAT0, '0);
    chk("masked flag", 32'h4, 32'(rd[5:0]));
    chk("masked irq", 32'h0, 32'(hotplug_irq_out));
    apb(1'b1, OFS_STAT0, 32'h0000_0004);
    apb(1'b1, OFS_MODE, 32'h0000_0001);
    apb(1'b1, OFS_CTRL0, 32'h003F_0141);
    pin(6'h01);
    apb(1'b0, OFS_STAT0, '0);
    chk("failover", 32'h508, 32'(rd[11:0]));
    chk("irq fail", 32'h1, 32'(hotplug_irq_out));
    apb(1'b1, OFS_STAT0, 32'h0000_0008);
    apb(1'b1, OFS_CTRL0, 32'h003F_0131);
    apb(1'b0, OFS_STAT0, '0);
    chk("disabled", 32'h308, 32'(rd[11:0]));
    apb(1'b1, OFS_STAT0, 32'h0000_0008);
    flush_lat <= 8'h28;
    apb(1'b1, OFS_DCCTRL, 32'h0000_0001);
    apb(1'b0, OFS_DCSTAT, '0);
    chk("flush early", 32'h0, 32'(rd[0]));
    poll(OFS_DCSTAT, 0);
    chk("flush done", 32'h1, 32'(rd[0]));
    apb(1'b1, OFS_CTRL0, 32'h003F_0161);
    apb(1'b0, OFS_STAT0, '0);
    chk("rec reset", 32'h6, 32'(rd[11:8]));
    chk("port_reset", 32'h1, 32'(slot_out[0].port_reset));
    apb(1'b1, OFS_CTRL0, 32'h003F_0009);
    chk("power", 32'h0, 32'(slot_out[0].slot_power_en));
    apb(1'b1, OFS_CTRL0, 32'h003F_000C);
    chk("green", 32'h0, 32'(slot_out[0].green_led));
    chk("amber", 32'h1, 32'(slot_out[0].amber_led));
    apb(1'b1, OFS_CTRL0, 32'h003F_0008);
    chk("amber off", 32'h0, 32'(slot_out[0].amber_led));
    // A second press inside the interval cancels the removal.
    pin(6'h08);
    apb(1'b1, OFS_STAT0, 32'h0000_0004);
    apb(1'b1, OFS_CTRL0, 32'h003F_0002);
    apb(1'b1, OFS_TIMER, 32'h0001_0064);
    pin(6'h08);
    apb(1'b0, OFS_TIMER, '0);
    chk("tmr pending", 32'h0, 32'(rd[31]));
    chk("second press", 32'h1, 32'(hotplug_irq_out));
    apb(1'b1, OFS_CTRL0, 32'h003F_0000);
    apb(1'b1, OFS_STAT0, 32'h0000_0004);
    apb(1'b0, OFS_STAT0, '0);
    chk("cancel flag", 32'h0, 32'(rd[5:0]));
    chk("cancel green", 32'h0, 32'(slot_out[0].green_led));
    apb(1'b1, OFS_TIMER, 32'h0001_0002);
    apb(1'b0, OFS_TIMER, '0);
    chk("tmr early", 32'h0, 32'(rd[31]));
    poll(OFS_TIMER, 31);
    chk("tmr irq", 32'h1, 32'(hotplug_irq_out));
    apb(1'b1, OFS_TIMER, 32'h8001_0000);
    chk("tmr clr", 32'h0, 32'(hotplug_irq_out));
    apb(1'b0, 8'h30, '0);
    chk("unmapped", 32'h1, 32'(er));
    stop_test();
  end
endmodule : memory_port_hot_removal_ctrl_tb

// [test/mhp_card_model.sv]
// Card-side model: slot pins of port 0 and the directory-cache flush
// engine. Assumes the bench requests pin levels; other slots stay idle.
`timescale 1ns/1ns
module mhp_card_model
  import mhp_pkg::*;
#(
  parameter int unsigned NP = NUM_PORTS
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Bench requests
  input  wire logic [5:0]        pins_req,
  input  wire logic [7:0]        flush_lat,
  // Device side
  output mhp_slot_in_s [NP-1:0]  slot_in,
  input  wire logic              dc_flush_start,
  output logic                   dc_flush_done
);
  logic [7:0] cnt_q;
  always_comb begin
    slot_in    = '0;
    slot_in[0] = mhp_slot_in_s'(pins_req);
  end
  // A long latency stands for a slow flush; done is a one-cycle pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q         <= '0;
      dc_flush_done <= 1'b0;
    end else begin
      dc_flush_done <= (cnt_q == 8'h01);
      if (dc_flush_start) begin
        cnt_q <= flush_lat;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : mhp_card_model

// [test/mhp_chk.sv]
// Port checker for the hot-plug controller, bound to every mhp_ctrl.
// Assumes zero-wait APB; slot checks look at port 0 only.
`timescale 1ns/1ns
module mhp_chk
  import mhp_pkg::*;
#(
  parameter int unsigned NP = NUM_PORTS
) (
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  // Outputs
  input wire mhp_slot_out_s [NP-1:0] slot_out,
  input wire logic                   dc_flush_start,
  input wire logic                   hotplug_irq_out
);
  wire wr_acc = psel && penable && pwrite && pready;
  wire wr_c0  = wr_acc && (paddr == OFS_CTRL0);
  // Slot outputs sit one register behind the control register, so a write
  // is seen on them at the second sampling edge after it is taken.
  wire wr_off = wr_c0 && pwdata[CTL_PWROFF];
  wire wr_amb = wr_c0 && pwdata[CTL_ALED];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_flush_start;
    dc_flush_start |-> wr_acc && paddr == OFS_DCCTRL && pwdata[0];
  endproperty
  a_flush_start: assert property (p_flush_start)
    else $error("flush start without flush write");
  property p_irq_hold;
    hotplug_irq_out && !wr_acc |=> hotplug_irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without a write");
  property p_reset_cause;
    $rose(slot_out[0].port_reset) |-> $past(wr_c0, 2);
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("port reset rose without control write");
  property p_reset_req;
    wr_c0 && pwdata[CTL_NEXT_VLD] && pwdata[7:4] == MHP_ST_RESET
      |-> ##2 slot_out[0].port_reset;
  endproperty
  a_reset_req: assert property (p_reset_req)
    else $error("reset state write left port out of reset");
  property p_power_cause;
    $fell(slot_out[0].slot_power_en) |-> $past(wr_off, 2);
  endproperty
  a_power_cause: assert property (p_power_cause)
    else $error("slot power fell without power-off write");
  property p_power_set;
    wr_c0 |-> ##2 slot_out[0].slot_power_en == !$past(wr_off, 2);
  endproperty
  a_power_set: assert property (p_power_set)
    else $error("slot power differs from written control");
  property p_amber_cause;
    $changed(slot_out[0].amber_led) |-> $past(wr_c0, 2);
  endproperty
  a_amber_cause: assert property (p_amber_cause)
    else $error("amber changed without control write");
  property p_amber_set;
    wr_c0 |-> ##2 slot_out[0].amber_led == $past(wr_amb, 2);
  endproperty
  a_amber_set: assert property (p_amber_set)
    else $error("amber differs from written control");
  property p_green_on;
    wr_c0 && pwdata[1:0] == MHP_LED_ON |-> ##2 slot_out[0].green_led;
  endproperty
  a_green_on: assert property (p_green_on)
    else $error("green off after on write");
  property p_green_off;
    wr_c0 && pwdata[1:0] == MHP_LED_OFF |-> ##2 !slot_out[0].green_led;
  endproperty
  a_green_off: assert property (p_green_off)
    else $error("green on after off write");
endmodule : mhp_chk

bind mhp_ctrl mhp_chk #(.NP(NP)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .slot_out(slot_out),
  .dc_flush_start(dc_flush_start), .hotplug_irq_out(hotplug_irq_out));
